/* File: core/adc_oversample_channel_select_regs.sv */
// Overview of operation
// [R1] Ratio codes 010..111 average 4,8,16,32,64,128 samples per channel.
// [R2] Ratio code 000 disables averaging; code 001 averages two samples.
// [R3] Status and checksum enables both low: no status word follows conversion words.
// [R4] Status enable high: status word follows all conversion words read.
// [R5] Appended status word carries the CRC in its low eight bits.
// [R6] Checksum enable acts exactly like status enable; either appends.
// [R7] Channel register picks pair or self-test source for next conversion.
// [R8] B field bits 7:4: pairs 0-7, supply 1000, regulator 1001.
// [R9] Code 1011 returns fixed 0xaaaa on A and 0x5555 on B.
// [R10] A field bits 3:0 decodes like B field, resets to zero.
// [R11] Register words carry the register address in bits 13 to 9.
// [R12] Channel register at address 3, resets to zero, pair zero.
// [R13] Bit 15 high writes bits 8:0; low makes next word a read.
// [R14] Select 00010 is configuration, 00011 is channel register.
// [R15] Channel writes apply at next conversion start, never mid-conversion.
`include "adc_regs_consts.svh"

module adc_oversample_channel_select_regs #(
   parameter int FIFO_DEPTH = 8
) (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic [15:0] host_word,
   input  wire logic        host_word_valid,
   input  wire logic        convst_pin,
   input  wire logic [15:0] sample_a,
   input  wire logic [15:0] sample_b,
   output logic      [15:0] read_word,
   output logic             read_word_valid,
   input  wire logic        read_word_ready,
   output logic             busy,
   output logic       [7:0] averaging_ratio,
   output logic       [3:0] active_channel_a,
   output logic       [3:0] active_channel_b
);
   ////////////////////////////////////////////////////////////////////////
   logic [8:0]  config_data;
   logic [8:0]  channel_data;
   logic [4:0]  read_sel;
   logic        read_pending;
   logic [1:0]  convst_sync;
   logic        convst_last;
   logic        convst_rise;
   logic [3:0]  conv_a;
   logic [3:0]  conv_b;
   logic [15:0] result_a;
   logic [15:0] result_b;
   logic [7:0]  crc;
   logic [$clog2(`CONV_CYCLES+1)-1:0] conv_count;
   adc_regs_pkg::conv_state_e state;
   logic [15:0] fifo_in;
   logic        fifo_in_valid;
   logic        fifo_in_ready;
   logic [15:0] fifo_out;
   logic        fifo_out_valid;
   logic        status_append;
   logic        host_write;
   logic [4:0]  host_sel;
   logic        start_conv;
   logic        conv_done;

   ////////////////////////////////////////////////////////////////////////
   function automatic adc_regs_pkg::source_e decode_source(
      input logic [3:0] code
   );
      if (code <= `CH_PAIR_MAX) begin
         return adc_regs_pkg::SRC_PAIR;
      end else if (code == `CH_SUPPLY) begin
         return adc_regs_pkg::SRC_SUPPLY;
      end else if (code == `CH_REGULATOR) begin
         return adc_regs_pkg::SRC_REGULATOR;
      end else begin
         return adc_regs_pkg::SRC_SELFTEST;
      end
   endfunction : decode_source

   function automatic logic [7:0] ratio_of(input logic [2:0] code);
      // Code 0 means no averaging: one sample per channel
      if (code == 3'h0) begin
         return 8'h01; // [R2]
      end
      return 8'h01 << code; // [R1] [R2]
   endfunction : ratio_of

   function automatic logic [7:0] crc_step(
      input logic [7:0]  crc_in,
      input logic [15:0] data
   );
      logic [7:0] c;
      c = crc_in;
      for (int i = 15; i >= 0; i--) begin
         c = (c[7] ^ data[i]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
      end
      return c;
   endfunction : crc_step

   ////////////////////////////////////////////////////////////////////////
   assign host_write = host_word[`WORD_WRITE_BIT]; // [R13]
   assign host_sel   = host_word[`WORD_SEL_HI:`WORD_SEL_LO]; // [R11]
   assign convst_rise = convst_sync[1] && !convst_last;
   assign status_append = config_data[`CFG_STATUS_BIT] ||
                          config_data[`CFG_CRC_BIT]; // [R3] [R6]
   // Edges seen outside idle are dropped, never queued
   assign start_conv = (state == adc_regs_pkg::ST_IDLE) && convst_rise;
   assign conv_done  = (state == adc_regs_pkg::ST_CONVERT) &&
      (conv_count == ($bits(conv_count))'(`CONV_CYCLES - 1));

   // Register writes; words with the page bit set change no register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         config_data  <= `CONFIG_RESET;
         channel_data <= `CHANNEL_RESET; // [R10] [R12]
      end else if (host_word_valid && host_write &&
                   !host_word[`WORD_PAGE_BIT]) begin // [R13]
         case (host_sel)
            `SEL_CONFIG:  config_data  <= host_word[8:0]; // [R14]
            `SEL_CHANNEL: channel_data <= host_word[8:0]; // [R14] [R12]
            default:      config_data  <= config_data;
         endcase
      end
   end

   // A read word only arms the next transfer
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         read_sel     <= `SEL_CONVERSION;
         read_pending <= 1'b0;
      end else if (host_word_valid && !host_write) begin // [R13]
         read_sel     <= host_sel; // [R11]
         read_pending <= !host_word[`WORD_PAGE_BIT];
      end else if (fifo_in_valid && fifo_in_ready &&
                   state == adc_regs_pkg::ST_IDLE) begin
         read_pending <= 1'b0;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         convst_sync <= 2'b00;
         convst_last <= 1'b0;
      end else begin
         convst_sync <= {convst_sync[0], convst_pin};
         convst_last <= convst_sync[1];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Conversion and readout sequence
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= adc_regs_pkg::ST_IDLE;
      end else begin
         case (state)
            adc_regs_pkg::ST_IDLE: begin
               if (convst_rise) begin
                  state <= adc_regs_pkg::ST_CONVERT; // [R7]
               end
            end
            adc_regs_pkg::ST_CONVERT: begin
               if (conv_done) begin
                  state <= adc_regs_pkg::ST_OUT_A;
               end
            end
            adc_regs_pkg::ST_OUT_A: begin
               if (fifo_in_ready) begin
                  state <= adc_regs_pkg::ST_OUT_B;
               end
            end
            adc_regs_pkg::ST_OUT_B: begin
               if (fifo_in_ready) begin
                  state <= status_append ? adc_regs_pkg::ST_OUT_STATUS :
                           adc_regs_pkg::ST_IDLE; // [R3] [R4]
               end
            end
            adc_regs_pkg::ST_OUT_STATUS: begin
               if (fifo_in_ready) begin
                  state <= adc_regs_pkg::ST_IDLE;
               end
            end
            default: state <= adc_regs_pkg::ST_IDLE;
         endcase
      end
   end

   // Conversion timer; stops at its last count until the next start
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         conv_count <= '0;
      end else if (start_conv) begin
         conv_count <= '0;
      end else if ((state == adc_regs_pkg::ST_CONVERT) && !conv_done) begin
         conv_count <= conv_count + 1'b1;
      end
   end

   // Latched only at start so writes never disturb a conversion
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         conv_a <= '0;
         conv_b <= '0;
      end else if (start_conv) begin
         conv_a <= channel_data[`CHA_HI:`CHA_LO]; // [R7] [R10] [R15]
         conv_b <= channel_data[`CHB_HI:`CHB_LO]; // [R8] [R15]
      end
   end

   // Self-test replaces the sample on each converter on its own
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         result_a <= '0;
         result_b <= '0;
      end else if (conv_done) begin
         result_a <= (decode_source(conv_a) ==
                      adc_regs_pkg::SRC_SELFTEST) ?
                     `SELFTEST_A : sample_a; // [R9] [R10]
         result_b <= (decode_source(conv_b) ==
                      adc_regs_pkg::SRC_SELFTEST) ?
                     `SELFTEST_B : sample_b; // [R9]
      end
   end

   // Checksum covers the A word, then the B word, as they are queued
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         crc <= '0;
      end else if (conv_done) begin
         crc <= '0;
      end else if (fifo_in_ready && (state == adc_regs_pkg::ST_OUT_A)) begin
         crc <= crc_step(crc, result_a); // [R5]
      end else if (fifo_in_ready && (state == adc_regs_pkg::ST_OUT_B)) begin
         crc <= crc_step(crc, result_b); // [R5]
      end
   end

   // Register readback goes through the same FIFO when idle
   always_comb begin
      fifo_in       = '0;
      fifo_in_valid = 1'b0;
      case (state)
         adc_regs_pkg::ST_OUT_A: begin
            fifo_in       = result_a;
            fifo_in_valid = 1'b1;
         end
         adc_regs_pkg::ST_OUT_B: begin
            fifo_in       = result_b;
            fifo_in_valid = 1'b1;
         end
         adc_regs_pkg::ST_OUT_STATUS: begin
            // Channel codes above, checksum in the low byte
            fifo_in       = {conv_a, conv_b, crc}; // [R4] [R5]
            fifo_in_valid = 1'b1;
         end
         adc_regs_pkg::ST_IDLE: begin
            fifo_in_valid = read_pending && read_sel != `SEL_CONVERSION;
            if (read_sel == `SEL_CONFIG) begin
               fifo_in = {read_sel, 2'b00, config_data}; // [R11]
            end else if (read_sel == `SEL_CHANNEL) begin
               fifo_in = {read_sel, 2'b00, channel_data}; // [R11]
            end else begin
               fifo_in = {read_sel, 2'b00, 9'h000};
            end
            fifo_in[15:9] = {2'b00, read_sel}; // [R11]
         end
         default: fifo_in = '0;
      endcase
   end

   word_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock     (clock),
      .rst       (rst),
      .in_data   (fifo_in),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out),
      .out_valid (fifo_out_valid),
      .out_ready (!read_word_valid || read_word_ready)
   );

   ////////////////////////////////////////////////////////////////////////
   // Registered outputs
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         read_word       <= '0;
         read_word_valid <= 1'b0;
      end else if (!read_word_valid || read_word_ready) begin
         read_word       <= fifo_out;
         read_word_valid <= fifo_out_valid;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         busy             <= 1'b0;
         averaging_ratio  <= 8'h01;
         active_channel_a <= '0;
         active_channel_b <= '0;
      end else begin
         busy             <= (state == adc_regs_pkg::ST_CONVERT);
         averaging_ratio  <= ratio_of(
            config_data[`CFG_RATIO_HI:`CFG_RATIO_LO]); // [R1] [R2]
         active_channel_a <= conv_a;
         active_channel_b <= conv_b;
      end
   end
endmodule : adc_oversample_channel_select_regs

/* File: core/adc_regs_consts.svh */
`ifndef ADC_REGS_CONSTS_SVH
`define ADC_REGS_CONSTS_SVH

// Register select codes carried in word bits [13:9]
`define SEL_CONFIG        5'h02
`define SEL_CHANNEL       5'h03
`define SEL_CONVERSION    5'h00
// Access word layout
`define WORD_WRITE_BIT    15
`define WORD_PAGE_BIT     14
`define WORD_SEL_HI       13
`define WORD_SEL_LO       9
// Configuration fields
`define CFG_RATIO_HI      4
`define CFG_RATIO_LO      2
`define CFG_STATUS_BIT    1
`define CFG_CRC_BIT       0
// Channel fields
`define CHB_HI            7
`define CHB_LO            4
`define CHA_HI            3
`define CHA_LO            0
// Reset values
`define CONFIG_RESET      9'h000
`define CHANNEL_RESET     9'h000
// Channel codes
`define CH_PAIR_MAX       4'h7
`define CH_SUPPLY         4'h8
`define CH_REGULATOR      4'h9
`define CH_SELFTEST       4'hb
// Fixed self-test codes
`define SELFTEST_A        16'haaaa
`define SELFTEST_B        16'h5555
// Conversion time at 20 MHz
`define CONV_TIME_NS      500
`define CLOCK_PERIOD_NS   50
`define CONV_CYCLES       ((`CONV_TIME_NS + `CLOCK_PERIOD_NS - 1) / \
                           `CLOCK_PERIOD_NS)

`endif

/* File: core/adc_regs_pkg.sv */
package adc_regs_pkg;
   typedef enum logic [1:0] {
      SRC_PAIR,
      SRC_SUPPLY,
      SRC_REGULATOR,
      SRC_SELFTEST
   } source_e;

   typedef enum {
      ST_IDLE,
      ST_CONVERT,
      ST_OUT_A,
      ST_OUT_B,
      ST_OUT_STATUS
   } conv_state_e;
endpackage : adc_regs_pkg

/* File: core/word_fifo.sv */
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   assign in_ready  = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
         end
         case ({push, pop})
            2'b10:   count <= count + 1'b1;
            2'b01:   count <= count - 1'b1;
            default: count <= count;
         endcase
      end
   end
endmodule : word_fifo

/* File: verification/adc_regs_chk.sv */
module adc_regs_chk (
   input wire logic        clock,
   input wire logic        rst,
   input wire logic [15:0] host_word,
   input wire logic        host_word_valid,
   input wire logic        convst_pin,
   input wire logic [15:0] sample_a,
   input wire logic [15:0] sample_b,
   input wire logic [15:0] read_word,
   input wire logic        read_word_valid,
   input wire logic        read_word_ready,
   input wire logic        busy,
   input wire logic [7:0]  averaging_ratio,
   input wire logic [3:0]  active_channel_a,
   input wire logic [3:0]  active_channel_b
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   ////////////////////////////////////////
   property p_valid_hold;
      read_word_valid && !read_word_ready |=> read_word_valid;
   endproperty
   a_valid_hold: assert property (p_valid_hold)
      else $error("word valid dropped early");
   property p_word_hold;
      read_word_valid && !read_word_ready |=> $stable(read_word);
   endproperty
   a_word_hold: assert property (p_word_hold)
      else $error("word changed while stalled");
   property p_ratio_onehot;
      $onehot(averaging_ratio);
   endproperty
   a_ratio_onehot: assert property (p_ratio_onehot)
      else $error("ratio not a power of two");
   property p_ratio_write;
      host_word_valid && host_word[15:9] == 7'h42 |-> ##2
         averaging_ratio == (8'h01 << $past(host_word[4:2], 2));
   endproperty
   a_ratio_write: assert property (p_ratio_write)
      else $error("ratio does not follow code");
   property p_chan_change;
      $changed(active_channel_a) || $changed(active_channel_b)
         |-> ##[0:2] busy;
   endproperty
   a_chan_change: assert property (p_chan_change)
      else $error("channel changed outside start");
   property p_hold_a;
      $rose(busy) |=> $stable(active_channel_a)[*8];
   endproperty
   a_hold_a: assert property (p_hold_a)
      else $error("channel a changed mid conversion");
   property p_hold_b;
      $rose(busy) |=> $stable(active_channel_b)[*8];
   endproperty
   a_hold_b: assert property (p_hold_b)
      else $error("channel b changed mid conversion");
   property p_busy_min;
      $rose(busy) |-> busy[*8];
   endproperty
   a_busy_min: assert property (p_busy_min)
      else $error("conversion too short");
endmodule : adc_regs_chk

/* File: verification/adc_host_model.sv */
module adc_host_model (
   input  wire logic        clock,
   input  wire logic        stall,
   input  wire logic        hold,
   input  wire logic        rnd_bit,
   output logic      [15:0] host_word,
   output logic             host_word_valid,
   output logic             read_word_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      host_word = 16'h0000;
      host_word_valid = 1'b0;
   end
   // Random back-pressure only when asked
   always @(posedge clock) begin
      read_word_ready <= hold ? 1'b0 : (stall ? rnd_bit : 1'b1);
   end
   // Word is not held after the pulse, so show its inverse
   task send(input logic [15:0] w);
      @(posedge clock);
      host_word <= w;
      host_word_valid <= 1'b1;
      @(posedge clock);
      host_word <= ~w;
      host_word_valid <= 1'b0;
   endtask : send
endmodule : adc_host_model

/* File: verification/adc_oversample_channel_select_regs_test.sv */
module adc_oversample_channel_select_regs_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock, rst, convst_pin, stall, hold;
   logic [15:0] sample_a, sample_b;
   logic [15:0] host_word, read_word;
   logic        host_word_valid, read_word_valid, read_word_ready, busy;
   logic [7:0]  averaging_ratio;
   logic [3:0]  active_channel_a, active_channel_b;
   logic [31:0] seed;
   logic [15:0] q[$];
   logic [7:0]  tbl[8] = '{8'h00, 8'h77, 8'h89, 8'h98,
                           8'h16, 8'h43, 8'h25, 8'h70};
   int          n_fail = 0, checks = 0, cycles = 0, n_out = 0;
   adc_oversample_channel_select_regs #(.FIFO_DEPTH(8)) u_dut (
      .clock(clock), .rst(rst), .host_word(host_word),
      .host_word_valid(host_word_valid), .convst_pin(convst_pin),
      .sample_a(sample_a), .sample_b(sample_b), .read_word(read_word),
      .read_word_valid(read_word_valid), .busy(busy),
      .read_word_ready(read_word_ready), .averaging_ratio(averaging_ratio),
      .active_channel_a(active_channel_a),
      .active_channel_b(active_channel_b));
   adc_host_model u_host (.clock(clock), .stall(stall), .hold(hold),
      .rnd_bit(seed[0]), .host_word(host_word),
      .host_word_valid(host_word_valid),
      .read_word_ready(read_word_ready));
   ////////////////////////////////////////
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   function automatic logic [7:0] crc8(input logic [31:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 31; i >= 0; i--)
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction : crc8
   task automatic cmp(input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : cmp
   task automatic final_report();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report
   task automatic drain();
      for (int k = 0; k < 300 && q.size() != 0; k++)
         @(posedge clock);
      cmp(16'(q.size()), 16'h0000);
      repeat (4) @(posedge clock);
   endtask : drain
   task automatic conv(input logic [7:0] ch, input logic [1:0] md,
                       input logic [7:0] mid);
      logic [15:0] a, b;
      u_host.send(16'h8400 | 16'(md));
      sample_a <= seed[15:0];
      sample_b <= seed[31:16];
      a = (ch == 8'hbb) ? 16'haaaa : seed[15:0];
      b = (ch == 8'hbb) ? 16'h5555 : seed[31:16];
      q.push_back(a);
      q.push_back(b);
      if (md != 2'b00) q.push_back({ch[3:0], ch[7:4], crc8({a, b})});
      @(posedge clock);
      convst_pin <= 1'b1;
      repeat (4) @(posedge clock);
      if (mid != ch) u_host.send(16'h8600 | 16'(mid));
      convst_pin <= 1'b0;
      drain();
      cmp(16'(active_channel_a), 16'(ch[3:0]));
      cmp(16'(active_channel_b), 16'(ch[7:4]));
   endtask : conv
   ////////////////////////////////////////
   always #25 clock = ~clock;
   always @(posedge clock) begin
      seed <= xs(seed);
      if (!rst && read_word_valid === 1'b1 && read_word_ready === 1'b1) begin
         n_out++;
         if (q.size() == 0) cmp(~read_word, read_word);
         else cmp(q.pop_front(), read_word);
      end
   end
   // Ceiling well above the roughly 500 cycles the tests need
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         final_report();
      end
   end
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      convst_pin = 1'b0;
      stall = 1'b0;
      hold = 1'b0;
      sample_a = 16'h0000;
      sample_b = 16'h0000;
      seed = 32'h1227;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      q.push_back(16'h0400);
      q.push_back(16'h0600);
      u_host.send(16'h0400);
      u_host.send(16'h0600);
      drain();
      cmp(16'(averaging_ratio), 16'h0001);
      $display("test reset_values done");
      for (int c = 0; c < 8; c++) begin
         u_host.send(16'h8400 | 16'(c << 2));
         q.push_back(16'h0400 | 16'(c << 2));
         u_host.send(16'h0400);
         drain();
         cmp(16'(averaging_ratio), 16'(8'h01 << c));
      end
      $display("test ratio_codes done");
      stall <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         u_host.send(16'h8600 | 16'(tbl[i]));
         conv(tbl[i], 2'(i), tbl[i]);
      end
      u_host.send(16'h86bb);
      conv(8'hbb, 2'd2, 8'h12);
      conv(8'h12, 2'd1, 8'h12);
      $display("test conversions done");
      u_host.send(16'h8bff);
      u_host.send(16'hc7ff);
      u_host.send(16'h0000);
      q.push_back(16'h0612);
      u_host.send(16'h0600);
      drain();
      stall <= 1'b0;
      $display("test unmapped done");
      // Reader held: one word out, eight queued, the tenth waits
      hold <= 1'b1;
      n_out = 0;
      @(posedge clock);
      for (int i = 0; i < 10; i++) begin
         q.push_back(i[0] ? 16'h0612 : 16'h0401);
         u_host.send(i[0] ? 16'h0600 : 16'h0400);
      end
      repeat (4) @(posedge clock);
      cmp(16'h0001, 16'(read_word_valid));
      cmp(16'h0401, read_word);
      repeat (8) @(posedge clock);
      cmp(16'h0401, read_word);
      hold <= 1'b0;
      drain();
      cmp(16'h000a, 16'(n_out));
      cmp(16'h0000, 16'(read_word_valid));
      $display("test fifo done");
      final_report();
   end
endmodule : adc_oversample_channel_select_regs_test

bind adc_oversample_channel_select_regs adc_regs_chk u_chk (
   .clock(clock), .rst(rst), .host_word(host_word),
   .host_word_valid(host_word_valid), .convst_pin(convst_pin),
   .sample_a(sample_a), .sample_b(sample_b), .read_word(read_word),
   .read_word_valid(read_word_valid), .read_word_ready(read_word_ready),
   .busy(busy), .averaging_ratio(averaging_ratio),
   .active_channel_a(active_channel_a), .active_channel_b(active_channel_b));
